// file: srf_channel.v
`timescale 1ns/1ps
`include "srf_map.vh"
module srf_channel #(
    parameter CNT_W    = 22,
    parameter TICK_CYC = `SRF_TICK_CYC
) (
    input  wire        aclk,
    input  wire        aresetn,
    input  wire [7:0]  s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output wire        s_axi_awready,
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output wire        s_axi_wready,
    output wire [1:0]  s_axi_bresp,
    output wire        s_axi_bvalid,
    input  wire        s_axi_bready,
    input  wire [7:0]  s_axi_araddr,
    input  wire        s_axi_arvalid,
    output wire        s_axi_arready,
    output wire [31:0] s_axi_rdata,
    output wire [1:0]  s_axi_rresp,
    output wire        s_axi_rvalid,
    input  wire        s_axi_rready,
    input  wire        rx_byte_valid,
    input  wire [7:0]  rx_byte,
    input  wire        rx_frame_start,
    input  wire        rx_bit_valid,
    input  wire        rx_bit,
    input  wire        rx_line,
    input  wire        rx_pop,
    input  wire        tx_push,
    input  wire        tx_pop,
    output wire        rx_store,
    output wire [7:0]  rx_store_byte,
    input  wire        tx_ready,
    output wire        tx_valid,
    output wire [7:0]  tx_byte,
    output wire        preamble_start,
    input  wire        preamble_start_req,
    input  wire        header_start_req,
    output wire        rts_out,
    output wire        irq,
    output wire        synced
);
    // ****************************************
    // bus slave: one write and one read in flight
    // ****************************************
    reg        aw_ok_ff, w_ok_ff, bvalid_ff, rvalid_ff;
    reg [7:0]  awaddr_ff;
    reg [31:0] wdata_ff, rdata_ff;
    reg [3:0]  wstrb_ff;
    reg [1:0]  bresp_ff, rresp_ff;
    reg [31:0] preamble_ff, tx_ae_ff, rx_af_ff, hwm_ff, lwm_ff, rxa_ff, txa_ff;
    reg [31:0] resume_ff, pause_ff, term_ff, tmo_ff, cfg_ff, ien_ff, isr_ff;
    reg [CNT_W-1:0] rx_cnt_ff, tx_cnt_ff;
    wire        wr_go = aw_ok_ff && w_ok_ff && !bvalid_ff;
    wire [31:0] fifo_stat;
    wire [31:0] isr_set;

    assign s_axi_awready = !aw_ok_ff && !bvalid_ff;
    assign s_axi_wready  = !w_ok_ff && !bvalid_ff;
    assign s_axi_bvalid  = bvalid_ff;
    assign s_axi_bresp   = bresp_ff;
    assign s_axi_arready = !rvalid_ff;
    assign s_axi_rvalid  = rvalid_ff;
    assign s_axi_rdata   = rdata_ff;
    assign s_axi_rresp   = rresp_ff;

    // byte-lane merge used by every writable register except interrupt status
    function [31:0] merge;
        input [31:0] old;
        input [31:0] nw;
        input [3:0]  st;
        integer i;
        begin
            merge = old;
            for (i = 0; i < 4; i = i + 1)
                if (st[i])
                    merge[i*8 +: 8] = nw[i*8 +: 8];
        end
    endfunction

    // decode: writable offset?
    function wr_map;
        input [7:0] a;
        begin
            wr_map = (a <= `SRF_OFS_INT_EN) && (a != `SRF_OFS_FIFO_STAT) && (a[1:0] == 2'h0);
        end
    endfunction

    // address and data captured in either order, response after both
    always @(posedge aclk) begin
        if (!aresetn) begin
            aw_ok_ff  <= 1'b0;
            w_ok_ff   <= 1'b0;
            bvalid_ff <= 1'b0;
            bresp_ff  <= 2'h0;
            awaddr_ff <= 8'h00;
            wdata_ff  <= 32'h0000_0000;
            wstrb_ff  <= 4'h0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_ok_ff  <= 1'b1;
                awaddr_ff <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_ok_ff  <= 1'b1;
                wdata_ff <= s_axi_wdata;
                wstrb_ff <= s_axi_wstrb;
            end
            if (wr_go) begin
                aw_ok_ff  <= 1'b0;
                w_ok_ff   <= 1'b0;
                bvalid_ff <= 1'b1;
                bresp_ff  <= wr_map(awaddr_ff) ? 2'h0 : 2'h2; // slverr for unmapped
            end else if (bvalid_ff && s_axi_bready) begin
                bvalid_ff <= 1'b0;
            end
        end
    end

    // register writes
    always @(posedge aclk) begin
        if (!aresetn) begin
            preamble_ff <= `SRF_RST_PREAMBLE;
            tx_ae_ff    <= `SRF_RST_TX_AE_LVL;
            rx_af_ff    <= `SRF_RST_RX_AF_LVL;
            hwm_ff      <= `SRF_RST_RX_HIGH_WM;
            lwm_ff      <= `SRF_RST_RX_LOW_WM;
            rxa_ff      <= `SRF_RST_ADDR;
            txa_ff      <= `SRF_RST_ADDR;
            resume_ff   <= `SRF_RST_RESUME;
            pause_ff    <= `SRF_RST_PAUSE;
            term_ff     <= `SRF_RST_TERM;
            tmo_ff      <= `SRF_RST_TIMEOUT;
            cfg_ff      <= 32'h0000_0000;
            ien_ff      <= 32'h0000_0000;
        end else if (wr_go) begin
            case (awaddr_ff)
                `SRF_OFS_PREAMBLE:   preamble_ff <= merge(preamble_ff, wdata_ff, wstrb_ff);
                `SRF_OFS_TX_AE_LVL:  tx_ae_ff    <= merge(tx_ae_ff, wdata_ff, wstrb_ff);
                `SRF_OFS_RX_AF_LVL:  rx_af_ff    <= merge(rx_af_ff, wdata_ff, wstrb_ff);
                `SRF_OFS_RX_HIGH_WM: hwm_ff      <= merge(hwm_ff, wdata_ff, wstrb_ff);
                `SRF_OFS_RX_LOW_WM:  lwm_ff      <= merge(lwm_ff, wdata_ff, wstrb_ff);
                `SRF_OFS_RX_ADDR:    rxa_ff      <= merge(rxa_ff, wdata_ff, wstrb_ff) & 32'h0000_ffff;
                `SRF_OFS_TX_ADDR:    txa_ff      <= merge(txa_ff, wdata_ff, wstrb_ff) & 32'h0000_ffff;
                `SRF_OFS_RESUME:     resume_ff   <= merge(resume_ff, wdata_ff, wstrb_ff) & 32'h0000_00ff;
                `SRF_OFS_PAUSE:      pause_ff    <= merge(pause_ff, wdata_ff, wstrb_ff) & 32'h0000_00ff;
                `SRF_OFS_TERM:       term_ff     <= merge(term_ff, wdata_ff, wstrb_ff) & 32'h0000_00ff;
                `SRF_OFS_TIMEOUT:    tmo_ff      <= merge(tmo_ff, wdata_ff, wstrb_ff) & 32'h0000_ffff;
                `SRF_OFS_CONFIG:     cfg_ff      <= merge(cfg_ff, wdata_ff, wstrb_ff) & 32'h0000_00ff;
                `SRF_OFS_INT_EN:     ien_ff      <= merge(ien_ff, wdata_ff, wstrb_ff);
                default: ;
            endcase
        end
    end

    // read mux; one cycle from ar handshake to rvalid
    always @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_ff <= 1'b0;
            rdata_ff  <= 32'h0000_0000;
            rresp_ff  <= 2'h0;
        end else if (s_axi_arvalid && !rvalid_ff) begin
            rvalid_ff <= 1'b1;
            rresp_ff  <= 2'h0;
            case (s_axi_araddr)
                `SRF_OFS_PREAMBLE:   rdata_ff <= preamble_ff;
                `SRF_OFS_TX_AE_LVL:  rdata_ff <= tx_ae_ff;
                `SRF_OFS_RX_AF_LVL:  rdata_ff <= rx_af_ff;
                `SRF_OFS_RX_HIGH_WM: rdata_ff <= hwm_ff;
                `SRF_OFS_RX_LOW_WM:  rdata_ff <= lwm_ff;
                `SRF_OFS_RX_ADDR:    rdata_ff <= rxa_ff;
                `SRF_OFS_TX_ADDR:    rdata_ff <= txa_ff;
                `SRF_OFS_RESUME:     rdata_ff <= resume_ff;
                `SRF_OFS_PAUSE:      rdata_ff <= pause_ff;
                `SRF_OFS_TERM:       rdata_ff <= term_ff;
                `SRF_OFS_TIMEOUT:    rdata_ff <= tmo_ff;
                `SRF_OFS_CONFIG:     rdata_ff <= cfg_ff;
                `SRF_OFS_FIFO_STAT:  rdata_ff <= fifo_stat;
                `SRF_OFS_INT_STAT:   rdata_ff <= isr_ff;
                `SRF_OFS_INT_EN:     rdata_ff <= ien_ff;
                `SRF_OFS_RX_COUNT:   rdata_ff <= {{(32-CNT_W){1'b0}}, rx_cnt_ff};
                `SRF_OFS_TX_COUNT:   rdata_ff <= {{(32-CNT_W){1'b0}}, tx_cnt_ff};
                default: begin
                    rdata_ff <= 32'h0000_0000;
                    rresp_ff <= 2'h2;
                end
            endcase
        end else if (rvalid_ff && s_axi_rready) begin
            rvalid_ff <= 1'b0;
        end
    end

    // ****************************************
    // occupancy counters and threshold compare
    // ****************************************
    wire [1:0] mode     = cfg_ff[`SRF_CF_MODE_LO +: 2];
    reg        hunt_ok_ff;
    reg        addr_ok_ff;
    wire       rx_keep  = (mode == `SRF_MODE_HDLC) ? addr_ok_ff :
                          (mode == `SRF_MODE_SYNC) ? hunt_ok_ff : 1'b1;
    wire       rx_in    = rx_byte_valid && rx_keep;
    assign rx_store      = rx_in;
    assign rx_store_byte = rx_byte;

    always @(posedge aclk) begin
        if (!aresetn) begin
            rx_cnt_ff <= {CNT_W{1'b0}};
            tx_cnt_ff <= {CNT_W{1'b0}};
        end else begin
            if (rx_in && !(rx_pop && rx_cnt_ff != 0))
                rx_cnt_ff <= rx_cnt_ff + 1'b1;
            else if (!rx_in && rx_pop && rx_cnt_ff != 0)
                rx_cnt_ff <= rx_cnt_ff - 1'b1;
            if (tx_push && !(tx_pop && tx_cnt_ff != 0))
                tx_cnt_ff <= tx_cnt_ff + 1'b1;
            else if (!tx_push && tx_pop && tx_cnt_ff != 0)
                tx_cnt_ff <= tx_cnt_ff - 1'b1;
        end
    end

    // thresholds assume software keeps low above zero and below high
    wire [31:0] rx_c32  = {{(32-CNT_W){1'b0}}, rx_cnt_ff};
    wire [31:0] tx_c32  = {{(32-CNT_W){1'b0}}, tx_cnt_ff};
    wire tx_ae  = tx_c32 <= tx_ae_ff;
    wire rx_af  = rx_c32 >= rx_af_ff;
    wire at_hwm = rx_c32 == hwm_ff;
    wire at_lwm = rx_c32 == lwm_ff;
    wire blw_lwm = rx_c32 < lwm_ff;
    assign fifo_stat = {26'h0, 1'b0, (rx_cnt_ff == 0), blw_lwm, at_hwm, tx_ae, rx_af};

    // ****************************************
    // flow control: none -> pause -> resume -> pause
    // ****************************************
    localparam FL_NONE  = 2'h0;
    localparam FL_PAUSE = 2'h1;
    localparam FL_RES   = 2'h2;
    reg [1:0] flow_ff;
    reg       pend_pause_ff, pend_res_ff, rts_ff;
    reg [7:0] pre_left_ff;
    reg [1:0] hdr_left_ff;
    wire sending_pre = pre_left_ff != 8'h00;
    wire sending_hdr = !sending_pre && hdr_left_ff != 2'h0;
    wire sw_flow = cfg_ff[`SRF_CF_SW_FLOW] && mode == `SRF_MODE_ASYNC;
    wire hw_flow = cfg_ff[`SRF_CF_HW_FLOW];

    always @(posedge aclk) begin
        if (!aresetn) begin
            flow_ff       <= FL_NONE;
            pend_pause_ff <= 1'b0;
            pend_res_ff   <= 1'b0;
            rts_ff        <= 1'b1;
        end else begin
            // clear first so a new request in the same cycle wins
            if (tx_ready && tx_valid && !sending_pre && !sending_hdr) begin
                pend_pause_ff <= 1'b0;
                pend_res_ff   <= 1'b0;
            end
            if (at_hwm) begin
                rts_ff <= 1'b0;
                if (sw_flow && flow_ff != FL_PAUSE) begin
                    flow_ff       <= FL_PAUSE;
                    pend_pause_ff <= 1'b1;
                    pend_res_ff   <= 1'b0;
                end
            end else if (blw_lwm || at_lwm) begin
                if (blw_lwm)
                    rts_ff <= 1'b1;
                if (sw_flow && at_lwm && flow_ff == FL_PAUSE) begin
                    flow_ff       <= FL_RES;
                    pend_res_ff   <= 1'b1;
                    pend_pause_ff <= 1'b0;
                end
            end
        end
    end
    assign rts_out = hw_flow ? rts_ff : cfg_ff[`SRF_CF_RTS_GPIO];

    // ****************************************
    // transmit insertion: preamble, header, flow chars
    // ****************************************
    always @(posedge aclk) begin
        if (!aresetn) begin
            pre_left_ff <= 8'h00;
            hdr_left_ff <= 2'h0;
        end else begin
            if (preamble_start_req && !sending_pre && mode != `SRF_MODE_ASYNC)
                pre_left_ff <= {4'h0, preamble_ff[15:12]};
            else if (sending_pre && tx_ready)
                pre_left_ff <= pre_left_ff - 8'h01;
            if (header_start_req && hdr_left_ff == 2'h0)
                hdr_left_ff <= cfg_ff[`SRF_CF_ADDR16] ? 2'h2 : 2'h1;
            else if (sending_hdr && tx_ready)
                hdr_left_ff <= hdr_left_ff - 2'h1;
        end
    end
    assign preamble_start = sending_pre;
    assign tx_valid = sending_pre || sending_hdr || pend_pause_ff || pend_res_ff;
    assign tx_byte  = sending_pre ? preamble_ff[7:0] :
                      sending_hdr ? (hdr_left_ff == 2'h2 ? txa_ff[15:8] : txa_ff[7:0]) :
                      pend_pause_ff ? pause_ff[7:0] : resume_ff[7:0];

    // ****************************************
    // receive side: address match, sync hunt, termination
    // ****************************************
    reg [15:0] shift_ff;
    reg [1:0]  abyte_ff;
    wire [15:0] sync_pat = cfg_ff[`SRF_CF_ADDR16] ? rxa_ff[15:0] : {8'h00, rxa_ff[7:0]};
    wire        hunt_hit = cfg_ff[`SRF_CF_ADDR16] ? ({shift_ff[14:0], rx_bit} == sync_pat)
                                                  : ({shift_ff[6:0], rx_bit} == sync_pat[7:0]);
    always @(posedge aclk) begin
        if (!aresetn) begin
            shift_ff   <= 16'h0000;
            hunt_ok_ff <= 1'b0;
            addr_ok_ff <= 1'b0;
            abyte_ff   <= 2'h0;
        end else begin
            if (mode != `SRF_MODE_SYNC)
                hunt_ok_ff <= 1'b0;
            else if (rx_bit_valid && !hunt_ok_ff) begin
                shift_ff <= {shift_ff[14:0], rx_bit};
                if (hunt_hit)
                    hunt_ok_ff <= 1'b1;
            end
            if (rx_frame_start) begin
                addr_ok_ff <= 1'b0;
                abyte_ff   <= cfg_ff[`SRF_CF_ADDR16] ? 2'h2 : 2'h1;
            end else if (rx_byte_valid && abyte_ff != 2'h0) begin
                abyte_ff <= abyte_ff - 2'h1;
                if (abyte_ff == 2'h2)
                    addr_ok_ff <= rx_byte == rxa_ff[15:8];
                else if (abyte_ff == 2'h1)
                    addr_ok_ff <= (cfg_ff[`SRF_CF_ADDR16] ? addr_ok_ff : 1'b1) && rx_byte == rxa_ff[7:0];
            end
        end
    end
    assign synced = hunt_ok_ff;

    // ****************************************
    // idle timeout, 25 us tick enable
    // ****************************************
    reg rxl_s1_ff, rxl_s2_ff, rxl_s3_ff;
    reg [15:0] tick_ff, idle_ff;
    wire tick = tick_ff == TICK_CYC - 1;
    wire activity = rxl_s2_ff != rxl_s3_ff;
    always @(posedge aclk) begin
        if (!aresetn) begin
            rxl_s1_ff <= 1'b1;
            rxl_s2_ff <= 1'b1;
            rxl_s3_ff <= 1'b1;
            tick_ff   <= 16'h0000;
            idle_ff   <= 16'h0000;
        end else begin
            rxl_s1_ff <= rx_line;
            rxl_s2_ff <= rxl_s1_ff;
            rxl_s3_ff <= rxl_s2_ff;
            tick_ff   <= tick ? 16'h0000 : tick_ff + 16'h0001;
            if (activity)
                idle_ff <= 16'h0000;
            else if (tick && idle_ff != 16'hffff)
                idle_ff <= idle_ff + 16'h0001;
        end
    end
    wire tmo_hit = mode == `SRF_MODE_ASYNC && cfg_ff[`SRF_CF_TMO_EN] && tick && !activity
                   && (idle_ff + 16'h0001) == tmo_ff[15:0];

    // ****************************************
    // interrupt status: set wins over write-one clear
    // ****************************************
    wire term_hit = cfg_ff[`SRF_CF_TERM_EN] && rx_byte_valid && rx_byte == term_ff[7:0]
                    && (mode == `SRF_MODE_ASYNC || mode == `SRF_MODE_SYNC);
    reg tx_ae_d_ff, rx_af_d_ff, hwm_d_ff, lwm_d_ff;
    assign isr_set = ({31'h0, tx_ae && !tx_ae_d_ff} << `SRF_IS_TX_AE)
                   | ({31'h0, rx_af && !rx_af_d_ff} << `SRF_IS_RX_AF)
                   | ({31'h0, at_hwm && !hwm_d_ff} << `SRF_IS_HIGH_WM)
                   | ({31'h0, blw_lwm && !lwm_d_ff} << `SRF_IS_LOW_WM)
                   | ({31'h0, tmo_hit} << `SRF_IS_TIMEOUT)
                   | ({31'h0, term_hit} << `SRF_IS_TERM)
                   | ({31'h0, mode == `SRF_MODE_SYNC && rx_bit_valid && !hunt_ok_ff && hunt_hit} << `SRF_IS_SYNC);
    always @(posedge aclk) begin
        if (!aresetn) begin
            isr_ff     <= 32'h0000_0000;
            tx_ae_d_ff <= 1'b0;
            rx_af_d_ff <= 1'b0;
            hwm_d_ff   <= 1'b0;
            lwm_d_ff   <= 1'b0;
        end else begin
            tx_ae_d_ff <= tx_ae;
            rx_af_d_ff <= rx_af;
            hwm_d_ff   <= at_hwm;
            lwm_d_ff   <= blw_lwm;
            isr_ff <= (isr_ff & ~((wr_go && awaddr_ff == `SRF_OFS_INT_STAT) ? wdata_ff : 32'h0)) | isr_set;
        end
    end
    assign irq = |(isr_ff & ien_ff);

endmodule // srf_channel

// file: srf_map.vh
`ifndef SRF_MAP_VH
`define SRF_MAP_VH
// ****************************************
// register byte offsets
// ****************************************
`define SRF_OFS_PREAMBLE    8'h00
`define SRF_OFS_TX_AE_LVL   8'h04
`define SRF_OFS_RX_AF_LVL   8'h08
`define SRF_OFS_RX_HIGH_WM  8'h0c
`define SRF_OFS_RX_LOW_WM   8'h10
`define SRF_OFS_RX_ADDR     8'h14
`define SRF_OFS_TX_ADDR     8'h18
`define SRF_OFS_RESUME      8'h1c
`define SRF_OFS_PAUSE       8'h20
`define SRF_OFS_TERM        8'h24
`define SRF_OFS_TIMEOUT     8'h28
`define SRF_OFS_CONFIG      8'h2c
`define SRF_OFS_FIFO_STAT   8'h30
`define SRF_OFS_INT_STAT    8'h34
`define SRF_OFS_INT_EN      8'h38
`define SRF_OFS_RX_COUNT    8'h3c
`define SRF_OFS_TX_COUNT    8'h40
// ****************************************
// reset values
// ****************************************
`define SRF_RST_PREAMBLE    32'h0000_0000
`define SRF_RST_TX_AE_LVL   32'h0000_0064
`define SRF_RST_RX_AF_LVL   32'h001f_ff9b
`define SRF_RST_RX_HIGH_WM  32'h001f_ff9b
`define SRF_RST_RX_LOW_WM   32'h0000_0800
`define SRF_RST_ADDR        32'h0000_00a5
`define SRF_RST_RESUME      32'h0000_0011
`define SRF_RST_PAUSE       32'h0000_0013
`define SRF_RST_TERM        32'h0000_0003
`define SRF_RST_TIMEOUT     32'h0000_9c40
// ****************************************
// field positions
// ****************************************
`define SRF_FS_RX_AF        0
`define SRF_FS_TX_AE        1
`define SRF_FS_HIGH_WM      2
`define SRF_FS_LOW_WM       3
`define SRF_FS_RX_EMPTY     4
`define SRF_IS_RX_AF        1
`define SRF_IS_HIGH_WM      6
`define SRF_IS_LOW_WM       7
`define SRF_IS_TX_AE        8
`define SRF_IS_TIMEOUT      10
`define SRF_IS_SYNC         12
`define SRF_IS_TERM         3
`define SRF_CF_HW_FLOW      0
`define SRF_CF_SW_FLOW      1
`define SRF_CF_TERM_EN      2
`define SRF_CF_TMO_EN       3
`define SRF_CF_ADDR16       4
`define SRF_CF_RTS_GPIO     5
`define SRF_CF_MODE_LO      6
// protocol modes in config bits 7:6
`define SRF_MODE_ASYNC      2'h0
`define SRF_MODE_SYNC       2'h1
`define SRF_MODE_HDLC       2'h2
// ****************************************
// timing
// ****************************************
`define SRF_TICK_NS         25000
`define SRF_CLK_NS          40
`define SRF_TICK_CYC        (`SRF_TICK_NS / `SRF_CLK_NS)
`endif

// file: srf_chk.sv
`timescale 1ns/1ps
// ****************************************
// handshake and stream checks
// ****************************************
module srf_chk (
    input logic       aclk,
    input logic       aresetn,
    input logic       s_axi_awvalid,
    input logic       s_axi_awready,
    input logic       s_axi_wvalid,
    input logic       s_axi_wready,
    input logic       s_axi_bvalid,
    input logic       s_axi_bready,
    input logic       s_axi_arvalid,
    input logic       s_axi_arready,
    input logic       s_axi_rvalid,
    input logic       s_axi_rready,
    input logic       rx_byte_valid,
    input logic [7:0] rx_byte,
    input logic       rx_store,
    input logic [7:0] rx_store_byte,
    input logic       tx_valid,
    input logic       tx_ready,
    input logic [7:0] tx_byte
);
    // one domain, so clock and reset are stated once
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid) else $error("bvalid dropped");
    AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid) else $error("rvalid dropped");
    AST_AR_BLOCK: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("read taken while busy");
    AST_AW_BLOCK: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready) else $error("write taken");
    AST_R_ANS: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("no read answer");
    AST_B_ANS: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        |-> ##2 s_axi_bvalid) else $error("no write answer");
    // an inserted byte may not change before the station takes it
    AST_TX_HOLD: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_byte)) else $error("tx moved");
    AST_STORE: assert property (rx_store |-> rx_byte_valid && rx_store_byte == rx_byte)
        else $error("bad store");
    // main scenarios reached
    cover property (tx_valid && tx_ready);
    cover property (rx_store);
    cover property (s_axi_rvalid && s_axi_rready);
endmodule // srf_chk
bind srf_channel srf_chk u_chk (.*);

// file: srf_station.sv
`timescale 1ns/1ps
// ****************************************
// remote station on the line side
// ****************************************
module srf_station (
    input  logic       aclk,
    input  logic       aresetn,
    input  logic       line_pulse,
    input  logic       tx_valid,
    input  logic [7:0] tx_byte,
    output logic       tx_ready,
    output logic       rx_line,
    output logic [7:0] last_byte,
    output logic [7:0] byte_cnt
);
    // ready every other cycle so the sender sees stalls; line idles at mark
    always @(posedge aclk) begin
        if (!aresetn) begin
            tx_ready <= 1'b0;
            byte_cnt <= 8'h00;
            rx_line  <= 1'b1;
        end else begin
            tx_ready <= ~tx_ready;
            rx_line  <= !line_pulse;
            if (tx_valid && tx_ready) begin
                last_byte <= tx_byte;
                byte_cnt <= byte_cnt + 8'h01;
            end
        end
    end
endmodule // srf_station

// file: srf_channel_test.sv
`timescale 1ns/1ps
// ****************************************
// channel bench
// ****************************************
module srf_channel_test;
    logic aclk = 1'b0, aresetn = 1'b0, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, rx_byte_valid = 1'b0, rx_frame_start = 1'b0;
    logic rx_bit_valid = 1'b0, rx_bit = 1'b0, rx_pop = 1'b0, tx_push = 1'b0, tx_pop = 1'b0;
    logic preamble_start_req = 1'b0, header_start_req = 1'b0, line_pulse = 1'b0;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, rx_byte = 8'h00, tx_byte, rx_store_byte;
    logic [7:0] last_byte, byte_cnt;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd_d;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic [1:0] s_axi_bresp, s_axi_rresp, rd_r, wr_r;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, rx_store;
    logic tx_valid, tx_ready, rx_line, preamble_start, rts_out, irq, synced;
    integer errors = 0, samples_checked = 0, i;
    // short tick so the idle timeout fits the run
    srf_channel #(.TICK_CYC(4)) dut (.*);
    srf_station st (.*);
    initial forever #20 aclk = ~aclk;
    task end_sim;
        $display("errors %0d samples_checked %0d", errors, samples_checked);
        if (errors == 0 && samples_checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task chk(input string n, input logic [31:0] e, input logic [31:0] g);
        samples_checked++;
        if (g !== e) begin
            errors++;
            $display("BAD %s exp %h got %h", n, e, g);
        end
    endtask
    // ready is sampled mid-cycle; it can only change at the rising edge
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic aw_t, w_t, b_t;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(negedge aclk);
            aw_t = s_axi_awvalid && s_axi_awready;
            w_t = s_axi_wvalid && s_axi_wready;
            b_t = s_axi_bvalid;
            wr_r = s_axi_bresp;
            @(posedge aclk);
            if (aw_t) s_axi_awvalid <= 1'b0;
            if (w_t) s_axi_wvalid <= 1'b0;
        end while (!b_t);
        s_axi_bready <= 1'b0;
        @(posedge aclk);
    endtask
    task automatic rd(input logic [7:0] a);
        logic t, v;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(negedge aclk);
            t = s_axi_arvalid && s_axi_arready;
            v = s_axi_rvalid;
            rd_d = s_axi_rdata;
            rd_r = s_axi_rresp;
            @(posedge aclk);
            if (t) s_axi_arvalid <= 1'b0;
        end while (!v);
        s_axi_rready <= 1'b0;
        @(posedge aclk);
    endtask
    task rc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        rd(a);
        chk($sformatf("reg_%h", a), e, rd_d & m);
    endtask
    // one received byte, or one byte read out of the buffer
    task pl(input logic k, input logic [7:0] b);
        rx_byte <= b;
        rx_pop <= k;
        rx_byte_valid <= !k;
        @(posedge aclk);
        rx_pop <= 1'b0;
        rx_byte_valid <= 1'b0;
        @(posedge aclk);
    endtask
    task wait_cnt(input logic [7:0] n);
        for (i = 0; i < 300 && byte_cnt !== n; i++) @(posedge aclk);
    endtask
    task t_reset;
        rc(8'h00, '1, 32'h0);
        rc(8'h04, '1, 32'h64);
        rc(8'h08, '1, 32'h1fff9b);
        rc(8'h0c, '1, 32'h1fff9b);
        rc(8'h10, '1, 32'h800);
        rc(8'h14, '1, 32'ha5);
        rc(8'h18, '1, 32'ha5);
        rc(8'h1c, '1, 32'h11);
        rc(8'h20, '1, 32'h13);
        rc(8'h24, '1, 32'h3);
        rc(8'h28, '1, 32'h9c40);
        rc(8'h30, 32'h1f, 32'h1a);
        rd(8'h80);
        chk("unmapped_resp", 32'h2, rd_r);
        wr(8'h80, 32'h0);
        chk("unmapped_bresp", 32'h2, wr_r);
    endtask
    // count 3 in bits 15:12, pattern dd; then tx level edge interrupts
    task t_pre;
        wr(8'h2c, 32'h40);
        wr(8'h00, 32'h30dd);
        preamble_start_req <= 1'b1;
        @(posedge aclk);
        preamble_start_req <= 1'b0;
        wait_cnt(8'h03);
        repeat (8) @(posedge aclk);
        chk("preamble", 8'hdd, last_byte);
        chk("preamble_cnt", 8'h03, byte_cnt);
        wr(8'h04, 32'h0);
        wr(8'h34, 32'h100);
        tx_push <= 1'b1;
        @(posedge aclk);
        tx_push <= 1'b0;
        rc(8'h40, '1, 32'h1);
        rc(8'h30, 32'h2, 32'h0);
        wr(8'h38, 32'h100);
        tx_pop <= 1'b1;
        @(posedge aclk);
        tx_pop <= 1'b0;
        rc(8'h40, '1, 32'h0);
        rc(8'h30, 32'h2, 32'h2);
        chk("irq", 1, irq);
    endtask
    // watermarks 2 and 4, both kinds of flow control on
    task t_flow;
        wr(8'h2c, 32'h3);
        wr(8'h10, 32'h2);
        wr(8'h0c, 32'h4);
        chk("rts", 1, rts_out);
        for (i = 0; i < 4; i++) pl(0, 8'h41);
        wait_cnt(8'h04);
        chk("pause", 8'h13, last_byte);
        chk("rts", 0, rts_out);
        rc(8'h30, 32'h4, 32'h4);
        rc(8'h34, 32'h40, 32'h40);
        pl(0, 8'h41);
        rc(8'h3c, '1, 32'h5);
        chk("no_repeat", 8'h04, byte_cnt);
        for (i = 0; i < 3; i++) pl(1, 8'h00);
        wait_cnt(8'h05);
        chk("resume", 8'h11, last_byte);
        pl(1, 8'h00);
        rc(8'h30, 32'h8, 32'h8);
        chk("rts", 1, rts_out);
    endtask
    task t_misc;
        wr(8'h2c, 32'h20);
        chk("rts", 1, rts_out);
        wr(8'h2c, 32'h4);
        chk("rts", 0, rts_out);
        wr(8'h38, 32'h8);
        pl(0, 8'h03);
        rc(8'h34, 32'h8, 32'h8);
        chk("irq", 1, irq);
        wr(8'h34, 32'h8);
        chk("irq", 0, irq);
        wr(8'h38, 32'h400);
        wr(8'h28, 32'h3);
        wr(8'h2c, 32'h8);
        // one line pulse restarts the idle count
        line_pulse <= 1'b1;
        @(posedge aclk);
        line_pulse <= 1'b0;
        for (i = 0; i < 300 && irq !== 1'b1; i++) @(posedge aclk);
        rc(8'h34, 32'h400, 32'h400);
    endtask
    // first frame carries a foreign address, second our own
    task t_hdlc;
        wr(8'h2c, 32'h80);
        for (i = 0; i < 2; i++) begin
            rx_frame_start <= 1'b1;
            @(posedge aclk);
            rx_frame_start <= 1'b0;
            pl(0, i ? 8'ha5 : 8'h5a);
            pl(0, 8'h41);
            rc(8'h3c, '1, 32'h2 + i);
        end
    endtask
    initial begin
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        t_reset;
        t_pre;
        t_flow;
        t_misc;
        t_hdlc;
        end_sim;
    end
    // hang guard, well beyond the few hundred cycles needed
    initial begin
        repeat (20000) @(posedge aclk);
        errors++;
        end_sim;
    end
endmodule // srf_channel_test
